// ==== hdl/dbrm_controller.sv ====
`default_nettype none
module dbrm_controller #(
    parameter int ADD_LAT = dbrm_pkg::ADD_LAT_CK,
    parameter int COL_LAT = dbrm_pkg::COL_LAT_CK,
    parameter int PRE_REC = dbrm_pkg::PRE_REC_CK,
    parameter int CK_HALF = dbrm_pkg::CK_HALF_SYS
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic dll_locked,
    dbrm_link_if.ctl link
);
    localparam int LAT = ADD_LAT + COL_LAT;

    if (LAT < 2 || LAT > 32 || PRE_REC < 1 || PRE_REC > 63 || CK_HALF < 4 || CK_HALF > 255) begin : g_bad_param
        $error("dbrm_controller: parameter out of range");
    end

    typedef enum logic [1:0] {
        DBRM_C_IDLE = 2'b00,
        DBRM_C_LAUNCH = 2'b01,
        DBRM_C_DRIVE = 2'b10,
        DBRM_C_WAIT = 2'b11
    } dbrm_cst_t;

    typedef struct packed {
        logic [7:0] div;
        logic ck;
        dbrm_cst_t st;
        logic [2:0] cmd;
        logic cs_n;
        logic [2:0] ba;
        logic [14:0] addr;
        logic [2:0] pin_cmd;
        logic [2:0] pin_ba;
        logic [14:0] pin_addr;
        logic [5:0] wait_ck;
        logic [7:0] open;
        logic rdout_on;
        logic err;
        logic rvalid;
        logic [63:0] rdata;
        logic capture;
        logic [3:0] expect_n;
        logic [3:0] cap_n;
        logic [8:0] sy1;
        logic [8:0] sy2;
        logic dqs_prev;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] rd;
    } dbrm_ctl_st_t;

    dbrm_ctl_st_t s;
    dbrm_ctl_st_t next_s;
    logic ck_fall;
    logic wr_cmd;
    dbrm_pkg::dbrm_op_t op;
    logic [2:0] w_ba;
    logic [14:0] w_addr;
    logic refuse;

    assign op = dbrm_pkg::dbrm_op_t'(hwdata[dbrm_pkg::CMD_OP_LSB +: 3]);
    assign w_ba = hwdata[dbrm_pkg::CMD_BANK_LSB +: 3];
    assign w_addr = hwdata[dbrm_pkg::CMD_ADDR_LSB +: 15];
    assign wr_cmd = s.ap_wr && s.ap_addr == dbrm_pkg::REG_CMD;

    // order checks before anything reaches the pins
    always_comb begin
        refuse = 1'b0;
        unique case (op)
            dbrm_pkg::DBRM_OP_ACT: refuse = s.open[w_ba];
            dbrm_pkg::DBRM_OP_RD: refuse = s.rdout_on ? ~dll_locked : ~s.open[w_ba];
            dbrm_pkg::DBRM_OP_WR: refuse = s.rdout_on | ~s.open[w_ba];
            dbrm_pkg::DBRM_OP_MRS: refuse = w_ba == dbrm_pkg::READOUT_BANK && w_addr[2] && w_addr[1:0] != 2'h0;
            dbrm_pkg::DBRM_OP_PRE: refuse = 1'b0;
            default: refuse = 1'b1;
        endcase
    end

    always_comb begin
        next_s = s;
        ck_fall = 1'b0;
        next_s.sy1 = {link.dqs, link.dq};
        next_s.sy2 = s.sy1;
        next_s.dqs_prev = s.sy2[8];
        // link clock divider, commands change on its falling edge
        if (s.div == 8'(CK_HALF - 1)) begin
            next_s.div = 8'h00;
            next_s.ck = ~s.ck;
            ck_fall = s.ck;
        end else begin
            next_s.div = s.div + 8'h01;
        end
        // register bus: address phase captured, data returned next cycle
        next_s.ap_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_s.ap_wr = hwrite;
            next_s.ap_addr = haddr[7:0];
            unique case (haddr[7:0])
                dbrm_pkg::REG_STATUS: next_s.rd = {20'h00000, s.rdout_on, s.open, s.rvalid, s.err, s.st != DBRM_C_IDLE};
                dbrm_pkg::REG_RDATA_LO: next_s.rd = s.rdata[31:0];
                dbrm_pkg::REG_RDATA_HI: next_s.rd = s.rdata[63:32];
                default: next_s.rd = 32'h00000000;
            endcase
        end
        if (wr_cmd) begin
            if (s.st != DBRM_C_IDLE || refuse) begin
                next_s.err = 1'b1;
            end else if (op != dbrm_pkg::DBRM_OP_NOP) begin
                next_s.err = 1'b0;
                next_s.st = DBRM_C_LAUNCH;
                next_s.ba = w_ba;
                next_s.addr = w_addr;
                next_s.wait_ck = 6'(dbrm_pkg::COL_GAP_CK);
                unique case (op)
                    dbrm_pkg::DBRM_OP_ACT: begin
                        next_s.cmd = dbrm_pkg::DBRM_CMD_ACT;
                        next_s.open[w_ba] = 1'b1;
                    end
                    dbrm_pkg::DBRM_OP_PRE: begin
                        next_s.cmd = dbrm_pkg::DBRM_CMD_PRE;
                        next_s.wait_ck = 6'(PRE_REC);
                        if (w_addr[dbrm_pkg::A_AP_BIT]) begin
                            next_s.open = 8'h00;
                        end else begin
                            next_s.open[w_ba] = 1'b0;
                        end
                    end
                    dbrm_pkg::DBRM_OP_RD: begin
                        next_s.cmd = dbrm_pkg::DBRM_CMD_RD;
                        // the rest of the burst must finish before the next command
                        next_s.wait_ck = 6'(LAT + dbrm_pkg::RD_TAIL_CK);
                        next_s.rvalid = 1'b0;
                        next_s.rdata = 64'h0;
                        next_s.capture = 1'b1;
                        next_s.cap_n = 4'h0;
                        next_s.expect_n = w_addr[dbrm_pkg::A_BL_BIT] ? dbrm_pkg::BEATS_FULL : dbrm_pkg::BEATS_CHOP;
                        if (s.rdout_on) begin
                            next_s.addr[1:0] = 2'h0;
                        end else if (w_addr[dbrm_pkg::A_AP_BIT]) begin
                            next_s.open[w_ba] = 1'b0;
                        end
                    end
                    dbrm_pkg::DBRM_OP_WR: begin
                        next_s.cmd = dbrm_pkg::DBRM_CMD_WR;
                        if (w_addr[dbrm_pkg::A_AP_BIT]) begin
                            next_s.open[w_ba] = 1'b0;
                        end
                    end
                    default: begin
                        next_s.cmd = dbrm_pkg::DBRM_CMD_MRS;
                        if (w_ba == dbrm_pkg::READOUT_BANK) begin
                            next_s.rdout_on = w_addr[dbrm_pkg::SEL_EN_BIT];
                        end
                    end
                endcase
            end
        end
        // command sequencing on link falling edges
        if (ck_fall) begin
            unique case (s.st)
                DBRM_C_IDLE: begin
                end
                DBRM_C_LAUNCH: begin
                    // command, bank and address pins load only here, so nothing moves while the device samples a rising edge
                    next_s.cs_n = 1'b0;
                    next_s.pin_cmd = s.cmd;
                    next_s.pin_ba = s.ba;
                    next_s.pin_addr = s.addr;
                    next_s.st = DBRM_C_DRIVE;
                end
                DBRM_C_DRIVE: begin
                    next_s.cs_n = 1'b1;
                    next_s.st = DBRM_C_WAIT;
                end
                DBRM_C_WAIT: begin
                    next_s.wait_ck = s.wait_ck - 6'h01;
                    if (s.wait_ck == 6'h01) begin
                        next_s.st = DBRM_C_IDLE;
                        next_s.capture = 1'b0;
                    end
                end
            endcase
        end
        // beats follow strobe changes; the first is its rise out of the preamble
        if (s.capture && s.cap_n != s.expect_n && s.sy2[8] != s.dqs_prev && (s.cap_n != 4'h0 || s.sy2[8])) begin
            next_s.rdata[{s.cap_n[2:0], 3'h0} +: 8] = s.sy2[7:0];
            next_s.cap_n = s.cap_n + 4'h1;
            if (s.cap_n + 4'h1 == s.expect_n) begin
                next_s.rvalid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.cs_n <= 1'b1;
            s.cmd <= dbrm_pkg::DBRM_CMD_NOP;
            s.pin_cmd <= dbrm_pkg::DBRM_CMD_NOP;
        end else begin
            s <= next_s;
        end
    end

    assign link.ck = s.ck;
    assign link.cs_n = s.cs_n;
    assign {link.ras_n, link.cas_n, link.we_n} = s.pin_cmd;
    assign link.ba = s.pin_ba;
    assign link.addr = s.pin_addr;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rd;
endmodule
`default_nettype wire

// ==== hdl/dbrm_pkg.sv ====
`default_nettype none
package dbrm_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ROW_W = 15;
    localparam int DQ_W = 8;
    // latencies and recovery are counted in link clock cycles
    localparam int ADD_LAT_CK = 0;
    localparam int COL_LAT_CK = 5;
    localparam int PRE_REC_CK = 6;
    localparam int COL_GAP_CK = 4;
    localparam int RD_TAIL_CK = 6;
    // controller makes the link clock: half period in clk_sys cycles
    localparam int CK_HALF_SYS = 8;
    localparam int A_AP_BIT = 10;
    localparam int A_BL_BIT = 12;
    localparam logic [2:0] READOUT_BANK = 3'h3;
    localparam int SEL_EN_BIT = 2;
    localparam logic [1:0] SEL_PATTERN = 2'h0;
    // bit p of the pattern is burst position p
    localparam logic [7:0] READOUT_PATTERN = 8'haa;
    localparam logic [2:0] CHOP_HI_START = 3'h4;
    localparam logic [3:0] BEATS_CHOP = 4'h4;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    // {ras_n, cas_n, we_n} with cs_n low
    typedef enum logic [2:0] {
        DBRM_CMD_MRS = 3'b000,
        DBRM_CMD_REF = 3'b001,
        DBRM_CMD_PRE = 3'b010,
        DBRM_CMD_ACT = 3'b011,
        DBRM_CMD_WR = 3'b100,
        DBRM_CMD_RD = 3'b101,
        DBRM_CMD_ZQ = 3'b110,
        DBRM_CMD_NOP = 3'b111
    } dbrm_cmd_t;
    typedef enum logic [2:0] {
        DBRM_OP_NOP = 3'h0,
        DBRM_OP_ACT = 3'h1,
        DBRM_OP_PRE = 3'h2,
        DBRM_OP_RD = 3'h3,
        DBRM_OP_WR = 3'h4,
        DBRM_OP_MRS = 3'h5
    } dbrm_op_t;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RDATA_LO = 8'h08;
    localparam logic [7:0] REG_RDATA_HI = 8'h0c;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BANK_LSB = 3;
    localparam int CMD_ADDR_LSB = 6;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_RVALID_BIT = 2;
    localparam int ST_OPEN_LSB = 3;
    localparam int ST_READOUT_BIT = 11;
endpackage
`default_nettype wire

// ==== hdl/dbrm_link_if.sv ====
`default_nettype none
interface dbrm_link_if;
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
    logic [7:0] dev_dq;
    logic dev_dq_oe_n;
    logic dev_dqs;
    logic dev_dqs_n;
    logic dev_dqs_oe_n;
    logic [7:0] dq;
    logic dqs;
    logic dqs_n;
    // wire levels: undriven data reads low, strobe pair parks low/high
    assign dq = dev_dq_oe_n ? 8'h00 : dev_dq;
    assign dqs = dev_dqs_oe_n ? 1'b0 : dev_dqs;
    assign dqs_n = dev_dqs_oe_n ? 1'b1 : dev_dqs_n;
    modport dev (
        input ck, cs_n, ras_n, cas_n, we_n, ba, addr,
        output dev_dq, dev_dq_oe_n, dev_dqs, dev_dqs_n, dev_dqs_oe_n
    );
    modport ctl (
        output ck, cs_n, ras_n, cas_n, we_n, ba, addr,
        input dq, dqs, dqs_n
    );
endinterface
`default_nettype wire

// ==== hdl/dbrm_device.sv ====
`default_nettype none
module dbrm_device #(
    parameter int ADD_LAT = dbrm_pkg::ADD_LAT_CK,
    parameter int COL_LAT = dbrm_pkg::COL_LAT_CK,
    parameter int PRE_REC = dbrm_pkg::PRE_REC_CK
) (
    input wire logic clk_sys,
    input wire logic srst,
    dbrm_link_if.dev link,
    input wire logic dll_locked,
    output logic [2:0] calibration_readout_select,
    output logic [7:0] bank_open,
    output logic [7:0] bank_recovering
);
    localparam int LAT = ADD_LAT + COL_LAT;

    if (LAT < 2 || LAT > 32 || PRE_REC < 1 || PRE_REC > 15) begin : g_bad_param
        $error("dbrm_device: latency must be 2..32 and recovery 1..15");
    end

    typedef struct packed {
        logic valid;
        logic rdout;
        logic [1:0] sel;
        logic chop;
        logic hi;
        logic [7:0] col;
    } dbrm_ent_t;

    typedef struct packed {
        logic ck;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [14:0] addr;
    } dbrm_pins_t;

    typedef struct packed {
        dbrm_pins_t sy1;
        dbrm_pins_t sy2;
        logic ck_prev;
        logic [2:0] sel;
        logic [7:0] open;
        logic [7:0][14:0] row;
        logic [7:0][3:0] rec;
        dbrm_ent_t [LAT-1:0] pipe;
        dbrm_ent_t cur;
        logic [2:0] pos;
        logic [3:0] left;
        logic on;
        logic [7:0] dq;
        logic dq_oe_n;
        logic dqs;
        logic dqs_oe_n;
    } dbrm_dev_st_t;

    dbrm_dev_st_t s;
    dbrm_dev_st_t next_s;
    dbrm_pins_t pins_in;
    dbrm_ent_t ent;
    dbrm_ent_t head;
    logic rise;
    logic fall;
    logic [2:0] cmd;

    // array reads return column plus position so a checker can predict them
    function automatic logic [7:0] beat_data(input dbrm_ent_t e, input logic [2:0] p);
        if (!e.rdout) begin
            beat_data = e.col + {5'h00, p};
        end else if (e.sel == dbrm_pkg::SEL_PATTERN) begin
            beat_data = {8{dbrm_pkg::READOUT_PATTERN[p]}};
        end else begin
            beat_data = 8'h00; // reserved codes give zero
        end
    endfunction

    // every link pin is off-domain and passes two flops
    assign pins_in = '{ck: link.ck, cs_n: link.cs_n, ras_n: link.ras_n, cas_n: link.cas_n,
                       we_n: link.we_n, ba: link.ba, addr: link.addr};
    assign cmd = {s.sy2.ras_n, s.sy2.cas_n, s.sy2.we_n};
    assign head = s.pipe[LAT-1];

    // command decode on link rising edges, read beats on both edges
    always_comb begin
        next_s = s;
        ent = '0;
        rise = s.sy2.ck & ~s.ck_prev;
        fall = ~s.sy2.ck & s.ck_prev;
        next_s.sy1 = pins_in;
        next_s.sy2 = s.sy1;
        next_s.ck_prev = s.sy2.ck;
        if (rise) begin
            for (int b = 0; b < dbrm_pkg::NUM_BANKS; b++) begin
                if (s.rec[b] != 4'h0) begin
                    next_s.rec[b] = s.rec[b] - 4'h1;
                end
            end
            if (!s.sy2.cs_n) begin
                unique case (cmd)
                    dbrm_pkg::DBRM_CMD_ACT: begin
                        next_s.open[s.sy2.ba] = 1'b1;
                        next_s.row[s.sy2.ba] = s.sy2.addr;
                    end
                    dbrm_pkg::DBRM_CMD_PRE: begin
                        // idle or recovering banks simply restart their timer
                        if (s.sy2.addr[dbrm_pkg::A_AP_BIT]) begin
                            next_s.open = 8'h00;
                            for (int b = 0; b < dbrm_pkg::NUM_BANKS; b++) begin
                                next_s.rec[b] = 4'(PRE_REC);
                            end
                        end else begin
                            next_s.open[s.sy2.ba] = 1'b0;
                            next_s.rec[s.sy2.ba] = 4'(PRE_REC);
                        end
                    end
                    dbrm_pkg::DBRM_CMD_RD: begin
                        ent.rdout = s.sel[dbrm_pkg::SEL_EN_BIT];
                        ent.sel = s.sel[1:0];
                        ent.chop = ~s.sy2.addr[dbrm_pkg::A_BL_BIT];
                        ent.hi = s.sy2.addr[2] & ent.chop;
                        ent.col = s.sy2.addr[7:0];
                        // readout ignores bank state; array reads need an open row
                        ent.valid = dll_locked & (ent.rdout | s.open[s.sy2.ba]);
                        if (s.sy2.addr[dbrm_pkg::A_AP_BIT] & ~ent.rdout) begin
                            next_s.open[s.sy2.ba] = 1'b0;
                            next_s.rec[s.sy2.ba] = 4'(PRE_REC);
                        end
                    end
                    dbrm_pkg::DBRM_CMD_WR: begin
                        if (s.sy2.addr[dbrm_pkg::A_AP_BIT] & s.open[s.sy2.ba]) begin
                            next_s.open[s.sy2.ba] = 1'b0;
                            next_s.rec[s.sy2.ba] = 4'(PRE_REC);
                        end
                    end
                    dbrm_pkg::DBRM_CMD_MRS: begin
                        if (s.sy2.ba == dbrm_pkg::READOUT_BANK) begin
                            next_s.sel = s.sy2.addr[2:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // one pipe stage per link cycle gives the read latency
            next_s.pipe = {s.pipe[LAT-2:0], ent};
            if (head.valid) begin
                next_s.cur = head;
                next_s.on = 1'b1;
                next_s.pos = head.hi ? dbrm_pkg::CHOP_HI_START : 3'h0;
                next_s.left = (head.chop ? dbrm_pkg::BEATS_CHOP : dbrm_pkg::BEATS_FULL) - 4'h1;
                next_s.dq = beat_data(head, head.hi ? dbrm_pkg::CHOP_HI_START : 3'h0);
                next_s.dq_oe_n = 1'b0;
                next_s.dqs = 1'b1;
                next_s.dqs_oe_n = 1'b0;
            end else if (s.left != 4'h0) begin
                next_s.pos = s.pos + 3'h1;
                next_s.left = s.left - 4'h1;
                next_s.dq = beat_data(s.cur, s.pos + 3'h1);
                next_s.dqs = 1'b1;
            end else if (s.on) begin
                // frame ends: released at the rise right after the last beat, which itself drives the low strobe half
                next_s.on = 1'b0;
                next_s.dq_oe_n = 1'b1;
                next_s.dqs = 1'b0;
                next_s.dqs_oe_n = 1'b1;
            end
            // preamble: strobe driven low one link cycle before a fresh burst
            if (s.pipe[LAT-2].valid && !next_s.on) begin
                next_s.dqs = 1'b0;
                next_s.dqs_oe_n = 1'b0;
            end
        end else if (fall && s.left != 4'h0) begin
            // strobe edges follow the sampled clock, so their phase wanders by a sync step
            next_s.pos = s.pos + 3'h1;
            next_s.left = s.left - 4'h1;
            next_s.dq = beat_data(s.cur, s.pos + 3'h1);
            next_s.dqs = 1'b0;
        end
    end

    // all state in one register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.sy1.cs_n <= 1'b1;
            s.sy2.cs_n <= 1'b1;
            s.dq_oe_n <= 1'b1;
            s.dqs_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.dev_dq = s.dq;
    assign link.dev_dq_oe_n = s.dq_oe_n;
    assign link.dev_dqs = s.dqs;
    assign link.dev_dqs_n = ~s.dqs;
    assign link.dev_dqs_oe_n = s.dqs_oe_n;
    assign calibration_readout_select = s.sel;
    assign bank_open = s.open;

    // recovery status per bank
    for (genvar g = 0; g < dbrm_pkg::NUM_BANKS; g++) begin : g_rec
        assign bank_recovering[g] = s.rec[g] != 4'h0;
    end
endmodule
`default_nettype wire

// ==== tb/dbrm_link_chk.sv ====
`default_nettype none
module dbrm_link_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [14:0] addr,
    input wire logic dev_dq_oe_n,
    input wire logic dev_dqs,
    input wire logic dev_dqs_n,
    input wire logic dev_dqs_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // window allows for the two-flop sampling of the link clock
    localparam int LAT_MIN = 84;
    localparam int LAT_MAX = 100;
    logic [7:0] run_len;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // cycles the data lines have been driven in the current frame
    always_ff @(posedge clk_sys) begin
        if (srst || dev_dq_oe_n) begin
            run_len <= 8'h00;
        end else begin
            run_len <= run_len + 8'h01;
        end
    end
    property p_dqs_pair; !dev_dqs_oe_n |-> dev_dqs_n == !dev_dqs; endproperty
    property p_dq_in_frame; !dev_dq_oe_n |-> !dev_dqs_oe_n; endproperty
    property p_beat_hold; $changed(dev_dqs) && !dev_dq_oe_n |=> $stable(dev_dqs)[*7]; endproperty
    property p_preamble; $fell(dev_dqs_oe_n) |-> (dev_dq_oe_n && !dev_dqs)[*8]; endproperty
    property p_cmd_stable; $rose(ck) |=> $stable({cs_n, ras_n, cas_n, we_n, ba, addr})[*7]; endproperty
    property p_cs_one_period; $fell(cs_n) |=> (!cs_n)[*8] ##8 cs_n; endproperty
    property p_read_lat; $fell(cs_n) && {ras_n, cas_n, we_n} == 3'h5 |-> ##[LAT_MIN:LAT_MAX] $fell(dev_dq_oe_n);
    endproperty
    property p_burst_len; $rose(dev_dq_oe_n) |-> run_len == 8'h20 || run_len == 8'h40; endproperty
    a_dqs_pair: assert property (p_dqs_pair) else $error("strobe pair not complementary");
    a_dq_in_frame: assert property (p_dq_in_frame) else $error("data driven without strobe");
    a_beat_hold: assert property (p_beat_hold) else $error("beat shorter than half link clock");
    a_preamble: assert property (p_preamble) else $error("strobe preamble broken");
    a_cmd_stable: assert property (p_cmd_stable) else $error("command pins move near rising edge");
    a_cs_one_period: assert property (p_cs_one_period) else $error("select not one link period");
    a_read_lat: assert property (p_read_lat) else $error("first beat not at read latency");
    a_burst_len: assert property (p_burst_len) else $error("burst not four or eight beats");
    c_read: cover property ($fell(dev_dq_oe_n));
    c_chop: cover property ($rose(dev_dq_oe_n) && run_len == 8'h20);
    c_pre: cover property ($fell(cs_n) && {ras_n, cas_n, we_n} == 3'h2);
endmodule
`default_nettype wire

// ==== tb/dram_bank_rows_read_burst_mpr_bench.sv ====
`default_nettype none
module dram_bank_rows_read_burst_mpr_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic dll_locked = 1'b1;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [2:0] sel;
    logic [7:0] bank_open;
    logic [7:0] bank_rec;
    logic [31:0] q;
    int num_errors = 0;
    int checked = 0;
    dbrm_link_if lnk ();
    always #2.5 clk_sys = ~clk_sys;
    // the one slave's hreadyout is the bus's hready
    dbrm_controller u_dbrm_controller (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .dll_locked(dll_locked), .link(lnk.ctl));
    dbrm_device u_dbrm_device (.clk_sys(clk_sys), .srst(srst), .link(lnk.dev), .dll_locked(dll_locked),
        .calibration_readout_select(sel), .bank_open(bank_open), .bank_recovering(bank_rec));
    dbrm_link_chk u_dbrm_link_chk (.clk_sys(clk_sys), .srst(srst), .ck(lnk.ck), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
        .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr), .dev_dq_oe_n(lnk.dev_dq_oe_n),
        .dev_dqs(lnk.dev_dqs), .dev_dqs_n(lnk.dev_dqs_n), .dev_dqs_oe_n(lnk.dev_dqs_oe_n));
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait for hready; a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            chk("hready", 32'h0, 32'h1);
            tally_and_finish();
        end
    endtask
    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    // issue a command, then poll busy so link spacing is kept
    task automatic cmd(input logic [2:0] op, input logic [2:0] bk, input logic [14:0] ad);
        int n;
        bus(1'b1, dbrm_pkg::REG_CMD, {11'h0, ad, bk, op});
        n = 0;
        do begin
            bus(1'b0, dbrm_pkg::REG_STATUS, 32'h0);
            n++;
        end while (q[dbrm_pkg::ST_BUSY_BIT] !== 1'b0 && n < 300);
        if (q[dbrm_pkg::ST_BUSY_BIT] !== 1'b0) begin
            chk("busy", 32'h1, 32'h0);
            tally_and_finish();
        end
    endtask
    task automatic rdat(input logic [31:0] lo, input logic [31:0] hi, input logic full);
        bus(1'b0, dbrm_pkg::REG_RDATA_LO, 32'h0);
        chk("rdata lo", q, lo);
        if (full) begin
            bus(1'b0, dbrm_pkg::REG_RDATA_HI, 32'h0);
            chk("rdata hi", q, hi);
        end
    endtask
    // status without rvalid, which refused reads leave alone
    task automatic sts(input logic [31:0] exp);
        bus(1'b0, dbrm_pkg::REG_STATUS, 32'h0);
        chk("status", q & 32'hffff_fffb, exp);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        sts(32'h0);
        cmd(dbrm_pkg::DBRM_OP_ACT, 3'h5, 15'h7abc);
        chk("bank_open", {24'h0, bank_open}, 32'h20);
        cmd(dbrm_pkg::DBRM_OP_ACT, 3'h5, 15'h0123);
        sts(32'h102);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h5, 15'h1010);
        rdat(32'h13121110, 32'h17161514, 1'b1);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h5, 15'h0020);
        rdat(32'h23222120, 32'h0, 1'b0);
        cmd(dbrm_pkg::DBRM_OP_ACT, 3'h2, 15'h0001);
        cmd(dbrm_pkg::DBRM_OP_PRE, 3'h5, 15'h0000);
        chk("bank_open", {24'h0, bank_open}, 32'h04);
        cmd(dbrm_pkg::DBRM_OP_PRE, 3'h5, 15'h0000);
        sts(32'h20);
        chk("recovering", {24'h0, bank_rec}, 32'h0);
        cmd(dbrm_pkg::DBRM_OP_PRE, 3'h0, 15'h0400);
        chk("bank_open", {24'h0, bank_open}, 32'h0);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h2, 15'h0000);
        sts(32'h2);
        cmd(dbrm_pkg::DBRM_OP_MRS, 3'h3, 15'h0004);
        chk("select", {29'h0, sel}, 32'h4);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h7, 15'h1000);
        rdat(32'hff00ff00, 32'hff00ff00, 1'b1);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h7, 15'h0000);
        rdat(32'hff00ff00, 32'h0, 1'b0);
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h0, 15'h0004);
        rdat(32'hff00ff00, 32'h0, 1'b0);
        dll_locked <= 1'b0;
        cmd(dbrm_pkg::DBRM_OP_RD, 3'h0, 15'h1000);
        sts(32'h802);
        dll_locked <= 1'b1;
        cmd(dbrm_pkg::DBRM_OP_MRS, 3'h3, 15'h0000);
        sts(32'h0);
        cmd(dbrm_pkg::DBRM_OP_MRS, 3'h3, 15'h0005);
        sts(32'h2);
        chk("select", {29'h0, sel}, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
